// [bmcr_pkg.sv]
// Purpose: shared constants and types of the bus master cycle sequencer
// Assumes: clk runs at twice the bus clock rate, two clk per bus state
// Notes: register offsets are byte addresses on a 32-bit APB
package bmcr_pkg;

  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;

  // config register fields
  localparam int CFG_SYNC_BUS = 0;
  localparam int CFG_WAIT_LO = 1;
  localparam int CFG_LATCH_RETRY = 3;
  localparam int CFG_RETRY_ASYNC = 4;
  localparam int CFG_HOLD_EDGE = 5;
  localparam logic [5:0] CFG_RESET = 6'h01;

  // address register fields
  localparam int ADR_AREA_LO = 24;
  localparam int ADR_WRITE = 31;

  // status and command register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_RETRY = 1;
  localparam int STAT_DONE = 2;
  localparam int CMD_GO = 0;

  localparam int SYNC_W = 22;
  localparam int IN_DATA_LO = 6;
  localparam int IN_ORDER = 5;
  localparam int IN_GRANT = 4;
  localparam int IN_ACK_LO = 2;
  localparam int IN_TERM = 1;
  localparam int IN_RETRY = 0;

  typedef enum logic [2:0] {
    S_IDLE, S_REQ, S_T1, S_T2W, S_T2, S_REL, S_TH, S_LATCH
  } bmcr_state_t;

  typedef struct packed {
    bmcr_state_t st;
    logic ph;
    logic [1:0] waits;
    logic term;
    logic retrySeen;
    logic ackEarly;
    logic firstWait;
    logic mode1;
    logic asyncMode;
    logic isWrite;
    logic pend;
    logic doneFlag;
    logic retryFlag;
    logic [5:0] cfg;
    logic [31:0] adrReg;
    logic [15:0] wdReg;
    logic [15:0] rdReg;
    logic [22:0] addrOut;
    logic [2:0] areaOut;
    logic dirOut;
    logic csB;
    logic asB;
    logic dsB;
    logic dOe;
    logic busReq;
    logic gaB;
    logic gaOe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bmcr_regs_t;

endpackage

// [bmcr_sync_if.sv]
// Purpose: carries raw pin levels into the synchroniser and back
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ns
interface bmcr_sync_if;
  logic [bmcr_pkg::SYNC_W-1:0] raw;
  logic [bmcr_pkg::SYNC_W-1:0] synced;
  modport sampler (input raw, output synced);
  modport user (output raw, input synced);
endinterface

// [bmcr_sync.sv]
// Purpose: two flip-flop synchroniser for every pin input
// Assumes: asynchronous active-low reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module bmcr_sync (
  input wire logic clk,
  input wire logic rst_b,
  bmcr_sync_if.sampler sif
);
  logic [bmcr_pkg::SYNC_W-1:0] meta_q;
  logic [bmcr_pkg::SYNC_W-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= sif.raw;
      sync_q <= meta_q;
    end
  end

  assign sif.synced = sync_q;
endmodule

// [bmcr_top.sv]
// Purpose: runs single master memory cycles with retry handling
// Assumes: clk at twice bus rate; ph 0 is the rising, ph 1 the falling half
// Notes: active-low strobes end in _b; APB answers with no wait state
// Functional notes
// - cycle start strobe, address, status, direction driven at T1 start; all but the cycle start strobe held
// - pin mode 1: mid T1 drop cycle start strobe, raise address strobe
// - mode 1 sync: sample acknowledge pair at T2 start, repeat T2 till low
// - reads in mode 1 or mode 0 async: data at mid T2, strobe mid T1
// - write data driven from mid T1
// - mode 1 sync writes with waits: data strobe at mid wait T2
// - mode 1 ends by removing address and data strobes at mid T2
// - mode 1 async: acknowledge sampled mid T1 and mid T2, synchronised
// - mode 1 async: sync terminate sampled at T2 start, partner meets setup
// - async end 1.5 clocks after acknowledge or 1 after sync terminate
// - async writes: data strobe mid first wait T2, at zero waits mid T2 unless acknowledged mid T1
// - mode 0: address valid with cycle start at T1, off at T2 start
// - mode 0 sync: ready sampled at edge ending T2, repeat until low
// - mode 0 sync: read data at T2 end, write data held till end
// - retry finishes cycle at T2 end and releases the bus
// - no latch: re-request and repeat; latch: wait flag clear and release
// - retry wins over acknowledge, sync terminate and ready
// - retry sampled at T2 start, or synchronised from mid T1
// - grant acknowledge high half clock before float; hold edge selectable
// - pin mode low is little-endian, high big-endian signalling
// - config bit picks synchronous or asynchronous master termination
// - 1 to 3 programmed waits after T1 ignore termination inputs
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
module bmcr_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic byteOrderModePin,
  input wire logic busGrantIn,
  output logic busRequestOut,
  output logic grantAckOut_b,
  output logic grantAckOe,
  output logic [22:0] addrOut,
  output logic [2:0] busAreaStatus,
  output logic dirOut,
  output logic cycleStartStrobe_b,
  output logic addrStrobe_b,
  output logic dataStrobe_b,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut,
  output logic dataOe,
  input wire logic [1:0] transferAck_b,
  input wire logic syncTerminate_b,
  input wire logic retryRequest_b
);
  bmcr_pkg::bmcr_regs_t q;
  bmcr_pkg::bmcr_regs_t d;
  bmcr_sync_if sif ();
  logic ackLow;
  logic readyLow;
  logic asyncLow;
  logic stermLow;
  logic retryLow;
  logic setup;
  logic access;
  logic mapped;
  logic [7:0] offs;
  logic [15:0] dIn;

  assign sif.raw = {dataIn, byteOrderModePin, busGrantIn, transferAck_b,
    syncTerminate_b, retryRequest_b};

  bmcr_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .sif(sif)
  );

  // all pins pass the synchroniser first
  assign ackLow = ~|sif.synced[bmcr_pkg::IN_ACK_LO +: 2];
  assign readyLow = ~sif.synced[bmcr_pkg::IN_ACK_LO];
  assign stermLow = ~sif.synced[bmcr_pkg::IN_TERM];
  assign retryLow = ~sif.synced[bmcr_pkg::IN_RETRY];
  assign dIn = sif.synced[bmcr_pkg::IN_DATA_LO +: 16];
  assign asyncLow = q.mode1 ? ackLow : readyLow;
  assign offs = paddr[7:0];
  assign setup = psel & ~penable;
  assign access = psel & penable & q.pready;
  assign mapped = paddr[31:8] == 24'h000000 && offs[1:0] == 2'h0 &&
    offs <= bmcr_pkg::OFF_STAT;

  // sampling done on the edge that opens a T2 state
  function automatic bmcr_pkg::bmcr_regs_t enterT2(
    input bmcr_pkg::bmcr_regs_t s);
    bmcr_pkg::bmcr_regs_t r;
    r = s;
    r.st = bmcr_pkg::S_T2;
    r.ph = 1'b0;
    if (!s.cfg[bmcr_pkg::CFG_RETRY_ASYNC] && retryLow)
      r.retrySeen = 1'b1;
    if (!s.asyncMode)
      r.term = s.mode1 & ackLow;
    else
      r.term = s.ackEarly | (s.mode1 & stermLow);
    r.ackEarly = 1'b0;
    return r;
  endfunction

  always_comb
  begin
    d = q;
    d.pready = setup;
    d.pslverr = setup & ~mapped;
    if (setup)
    begin
      unique case (offs)
        bmcr_pkg::OFF_CFG: d.prdata = {26'h0000000, q.cfg};
        bmcr_pkg::OFF_ADDR: d.prdata = q.adrReg;
        bmcr_pkg::OFF_WDATA: d.prdata = {16'h0000, q.wdReg};
        bmcr_pkg::OFF_RDATA: d.prdata = {16'h0000, q.rdReg};
        bmcr_pkg::OFF_STAT: d.prdata = {29'h00000000, q.doneFlag,
          q.retryFlag, q.pend | (q.st != bmcr_pkg::S_IDLE)};
        default: d.prdata = 32'h00000000;
      endcase
    end
    if (access && pwrite && !q.pslverr)
    begin
      unique case (offs)
        bmcr_pkg::OFF_CFG: d.cfg = pwdata[5:0];
        bmcr_pkg::OFF_ADDR: d.adrReg = pwdata;
        bmcr_pkg::OFF_WDATA: d.wdReg = pwdata[15:0];
        bmcr_pkg::OFF_CMD:
          if (pwdata[bmcr_pkg::CMD_GO]) d.pend = 1'b1;
        bmcr_pkg::OFF_STAT:
        begin
          if (pwdata[bmcr_pkg::STAT_RETRY]) d.retryFlag = 1'b0;
          if (pwdata[bmcr_pkg::STAT_DONE]) d.doneFlag = 1'b0;
        end
        default: d.pend = q.pend;
      endcase
    end
    // asynchronous retry is watched from mid T1 onward
    if (q.cfg[bmcr_pkg::CFG_RETRY_ASYNC] && retryLow &&
      ((q.st == bmcr_pkg::S_T1 && q.ph) || q.st == bmcr_pkg::S_T2W ||
      q.st == bmcr_pkg::S_T2))
      d.retrySeen = 1'b1;
    unique case (q.st)
      bmcr_pkg::S_IDLE:
        if (q.pend)
        begin
          d.pend = 1'b0;
          d.busReq = 1'b1;
          d.st = bmcr_pkg::S_REQ;
          d.mode1 = sif.synced[bmcr_pkg::IN_ORDER];
          d.asyncMode = ~q.cfg[bmcr_pkg::CFG_SYNC_BUS];
          d.isWrite = q.adrReg[bmcr_pkg::ADR_WRITE];
        end
      bmcr_pkg::S_REQ:
        if (sif.synced[bmcr_pkg::IN_GRANT])
        begin
          d.st = bmcr_pkg::S_T1;
          d.ph = 1'b0;
          d.addrOut = q.adrReg[22:0];
          d.areaOut = q.adrReg[bmcr_pkg::ADR_AREA_LO +: 3];
          d.dirOut = q.mode1 ? ~q.isWrite : q.isWrite;
          d.csB = 1'b0;
          d.asB = q.mode1;
          d.gaB = 1'b0;
          d.gaOe = 1'b1;
          d.waits = q.cfg[bmcr_pkg::CFG_WAIT_LO +: 2];
          d.term = 1'b0;
          d.retrySeen = 1'b0;
          d.ackEarly = 1'b0;
          d.firstWait = 1'b0;
        end
      bmcr_pkg::S_T1:
        if (!q.ph)
        begin
          d.ph = 1'b1;
          d.csB = 1'b1;
          if (q.mode1)
            d.asB = 1'b0;
          if (!q.isWrite && (q.mode1 || q.asyncMode))
            d.dsB = 1'b0;
          if (q.isWrite)
            d.dOe = 1'b1;
          if (q.asyncMode && q.waits == 2'h0 && asyncLow)
            d.ackEarly = 1'b1;
        end
        else
        begin
          if (!q.mode1)
            d.asB = 1'b1;
          if (q.waits != 2'h0)
          begin
            d.st = bmcr_pkg::S_T2W;
            d.ph = 1'b0;
          end
          else
            d = enterT2(d);
        end
      bmcr_pkg::S_T2W:
        if (!q.ph)
        begin
          d.ph = 1'b1;
          if (q.isWrite && !q.firstWait && (q.mode1 || q.asyncMode))
          begin
            d.dsB = 1'b0;
            d.firstWait = 1'b1;
          end
          if (q.asyncMode && q.waits == 2'h1 && asyncLow)
            d.ackEarly = 1'b1;
        end
        else
        begin
          d.waits = q.waits - 2'h1;
          if (q.waits == 2'h1)
            d = enterT2(d);
          else
            d.ph = 1'b0;
        end
      bmcr_pkg::S_T2:
        if (!q.ph)
        begin
          d.ph = 1'b1;
          if ((q.term || d.retrySeen) && (q.mode1 || q.asyncMode))
          begin
            if (q.mode1)
              d.asB = 1'b1;
            d.dsB = 1'b1;
            if (!q.isWrite && !d.retrySeen)
              d.rdReg = dIn;
          end
          else if (q.mode1 || q.asyncMode)
          begin
            if (q.isWrite && !q.firstWait)
            begin
              d.dsB = 1'b0;
              d.firstWait = 1'b1;
            end
            if (q.asyncMode && asyncLow)
              d.ackEarly = 1'b1;
          end
        end
        else if (q.retrySeen || q.term || (!q.mode1 && !q.asyncMode &&
          readyLow))
        begin
          if (!q.mode1 && !q.asyncMode && !q.isWrite && !q.retrySeen)
            d.rdReg = dIn;
          if (q.retrySeen)
            d.retryFlag = 1'b1;
          else
            d.doneFlag = 1'b1;
          d.st = bmcr_pkg::S_REL;
          d.ph = 1'b0;
          d.dOe = 1'b0;
          d.dsB = 1'b1;
          d.asB = 1'b1;
          d.gaB = 1'b1;
          if (!q.cfg[bmcr_pkg::CFG_HOLD_EDGE])
            d.busReq = 1'b0;
        end
        else
          d = enterT2(d);
      bmcr_pkg::S_REL:
        if (!q.ph)
        begin
          d.ph = 1'b1;
          d.gaOe = 1'b0;
          d.busReq = 1'b0;
          d.addrOut = 23'h000000;
          d.areaOut = 3'h7;
        end
        else
        begin
          d.ph = 1'b0;
          d.st = q.retrySeen ? bmcr_pkg::S_TH : bmcr_pkg::S_IDLE;
        end
      bmcr_pkg::S_TH:
        if (!q.ph)
          d.ph = 1'b1;
        else
        begin
          d.ph = 1'b0;
          if (q.cfg[bmcr_pkg::CFG_LATCH_RETRY])
            d.st = bmcr_pkg::S_LATCH;
          else
          begin
            d.st = bmcr_pkg::S_REQ;
            d.busReq = 1'b1;
          end
        end
      bmcr_pkg::S_LATCH:
        if (!q.retryFlag && !retryLow)
        begin
          d.st = bmcr_pkg::S_REQ;
          d.busReq = 1'b1;
        end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.st <= bmcr_pkg::S_IDLE;
      q.cfg <= bmcr_pkg::CFG_RESET;
      q.areaOut <= 3'h7;
      q.csB <= 1'b1;
      q.asB <= 1'b1;
      q.dsB <= 1'b1;
      q.gaB <= 1'b1;
    end
    else
      q <= d;
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign busRequestOut = q.busReq;
  assign grantAckOut_b = q.gaB;
  assign grantAckOe = q.gaOe;
  assign addrOut = q.addrOut;
  assign busAreaStatus = q.areaOut;
  assign dirOut = q.dirOut;
  assign cycleStartStrobe_b = q.csB;
  assign addrStrobe_b = q.asB;
  assign dataStrobe_b = q.dsB;
  assign dataOut = q.wdReg;
  assign dataOe = q.dOe;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence sRelease;
    q.st == bmcr_pkg::S_REL && !q.ph && q.gaB && q.gaOe ##1
      q.st == bmcr_pkg::S_REL && q.ph && !q.gaOe;
  endsequence

  a_addr_stable: assert property (
    (q.st == bmcr_pkg::S_T2 || q.st == bmcr_pkg::S_T2W) |->
      $stable(q.addrOut) && $stable(q.dirOut) && $stable(q.areaOut))
    else $error("address moved inside a memory cycle");

  a_cs_one_clock: assert property (
    $fell(q.csB) |=> q.csB && q.st == bmcr_pkg::S_T1 && q.ph)
    else $error("cycle start strobe not one half state");

  a_as_mid_t1: assert property (
    q.st == bmcr_pkg::S_T1 && q.ph && q.mode1 |-> !q.asB)
    else $error("address strobe missing at mid T1");

  a_ads_off_t2: assert property (
    q.st == bmcr_pkg::S_T2 && !q.mode1 |-> q.asB)
    else $error("address valid strobe still on in T2");

  a_retry_wins: assert property (
    q.st == bmcr_pkg::S_T2 && q.ph && q.retrySeen |=>
      q.st == bmcr_pkg::S_REL && q.retryFlag && !q.dOe)
    else $error("retry did not end the cycle");

  a_no_zero_ds: assert property (
    q.asyncMode && q.isWrite && !q.firstWait |-> q.dsB)
    else $error("data strobe in zero wait write");

  a_release_seq: assert property (
    q.st == bmcr_pkg::S_T2 && d.st == bmcr_pkg::S_REL |=> sRelease)
    else $error("grant acknowledge release order wrong");

  a_wait_ignore: assert property (
    q.st == bmcr_pkg::S_T2W |=>
      q.st == bmcr_pkg::S_T2W || q.st == bmcr_pkg::S_T2)
    else $error("cycle ended during programmed wait");

  a_latch_hold: assert property (
    q.st == bmcr_pkg::S_LATCH && q.retryFlag |=>
      q.st == bmcr_pkg::S_LATCH && !q.busReq)
    else $error("latched retry left early");

  a_sync_ack_end: assert property (
    q.st == bmcr_pkg::S_T2 && !q.ph && q.term && q.mode1 |=>
      q.asB && q.dsB ##1 q.st == bmcr_pkg::S_REL)
    else $error("acknowledged cycle did not end");
endmodule

// [bmcr_mem_model.sv]
// Purpose: memory, arbiter and retry side of the master bus
// Assumes: grant follows request one clk later
// Notes: data lines toggle whenever memory does not drive them
`timescale 1ns/1ns
module bmcr_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic byteOrderModePin,
  input wire logic slow,
  input wire logic useTerm,
  input wire logic doRetry,
  input wire logic early,
  input wire logic busRequestOut,
  input wire logic grantAckOut_b,
  input wire logic cycleStartStrobe_b,
  input wire logic dirOut,
  input wire logic [22:0] addrOut,
  input wire logic [15:0] dataOut,
  input wire logic dataOe,
  output logic busGrantIn,
  output logic [15:0] dataIn,
  output logic [1:0] transferAck_b,
  output logic syncTerminate_b,
  output logic retryRequest_b
);
  logic [15:0] mem [16];
  logic [3:0] cnt_q;
  logic term;
  logic rd;
  initial
  begin
    for (int k = 0; k < 16; k++)
      mem[k] = 16'h5a00 + 16'(k);
  end
  // held off through address phase, dropped once the cycle ends
  // early: acknowledge already low from grant on, so T1 meets its setup
  assign term = early ? busGrantIn : (!grantAckOut_b && cycleStartStrobe_b &&
    cnt_q >= (slow ? 4'h6 : 4'h2));
  assign transferAck_b = (term && !useTerm) ? 2'h0 : 2'h3;
  assign syncTerminate_b = !(term && useTerm);
  assign retryRequest_b = !doRetry;
  assign rd = byteOrderModePin ? dirOut : !dirOut;
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 4'h0;
      busGrantIn <= 1'b0;
      dataIn <= 16'h0;
    end
    else
    begin
      busGrantIn <= busRequestOut;
      if (!cycleStartStrobe_b)
        cnt_q <= 4'h0;
      else if (cnt_q != 4'hf)
        cnt_q <= cnt_q + 4'h1;
      if (!grantAckOut_b && rd)
        dataIn <= mem[addrOut[3:0]];
      else
        dataIn <= ~dataIn;
      if (dataOe)
        mem[addrOut[3:0]] <= dataOut;
    end
  end
endmodule

// [bmcr_tb.sv]
// Purpose: self-checking bench of the master cycle sequencer
// Assumes: memory model on the far side of the master bus
// Notes: each scenario is a task that judges its own results
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic byteOrderModePin = 1'b0;
  logic slow = 1'b0;
  logic useTerm = 1'b0;
  logic doRetry = 1'b0;
  logic early = 1'b0;
  logic inCyc = 1'b0;
  logic [31:0] prdata, rdv, curPins, capPins;
  logic pready, pslverr, errv, busGrantIn, busRequestOut;
  logic grantAckOut_b, grantAckOe, dirOut, dataOe, syncTerminate_b;
  logic cycleStartStrobe_b, addrStrobe_b, dataStrobe_b, retryRequest_b;
  logic [22:0] addrOut;
  logic [2:0] busAreaStatus;
  logic [15:0] dataIn, dataOut;
  logic [1:0] transferAck_b;
  logic dsSeen, prevOe, prevGa;
  int failures = 0;
  int num_checks = 0;
  int csCount = 0;
  int cycles = 0;

  bmcr_top bmcr_top_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .byteOrderModePin, .busGrantIn,
    .busRequestOut, .grantAckOut_b, .grantAckOe, .addrOut, .busAreaStatus,
    .dirOut, .cycleStartStrobe_b, .addrStrobe_b, .dataStrobe_b, .dataIn,
    .dataOut, .dataOe, .transferAck_b, .syncTerminate_b, .retryRequest_b);
  bmcr_mem_model bmcr_mem_model_i (.clk, .rst_b, .byteOrderModePin, .slow,
    .useTerm, .doRetry, .early, .busRequestOut, .grantAckOut_b,
    .cycleStartStrobe_b, .dirOut, .addrOut, .dataOut, .dataOe, .busGrantIn,
    .dataIn, .transferAck_b, .syncTerminate_b, .retryRequest_b);

  always #5 clk = ~clk;
  assign curPins = {5'h0, dirOut, busAreaStatus, addrOut};

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 32'(a);
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pin watcher: cycle start, held pins, data strobe, grant release
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
    prevOe <= grantAckOe;
    prevGa <= grantAckOut_b;
    if (prevOe === 1'b1 && grantAckOe === 1'b0)
      check(32'(prevGa), 32'h1);
    if (cycleStartStrobe_b === 1'b0)
    begin
      csCount <= csCount + 1;
      inCyc <= 1'b1;
      dsSeen <= 1'b0;
      capPins <= curPins;
      check(32'(addrStrobe_b), 32'(byteOrderModePin));
    end
    else if (grantAckOut_b === 1'b1)
      inCyc <= 1'b0;
    else if (inCyc)
    begin
      dsSeen <= dsSeen | !dataStrobe_b;
      check(curPins, capPins);
    end
  end

  task automatic startCycle(input logic [31:0] cfg, input logic wrt,
    input logic [3:0] idx, input logic [15:0] wd);
    apb(1'b1, bmcr_pkg::OFF_CFG, cfg);
    apb(1'b1, bmcr_pkg::OFF_ADDR, {wrt, 4'h0, 3'h5, 20'h0, idx});
    apb(1'b1, bmcr_pkg::OFF_WDATA, 32'(wd));
    apb(1'b1, bmcr_pkg::OFF_CMD, 32'h1);
  endtask

  task automatic waitDone();
    do
      apb(1'b0, bmcr_pkg::OFF_STAT, 32'h0);
    while (rdv[bmcr_pkg::STAT_DONE] !== 1'b1);
    apb(1'b1, bmcr_pkg::OFF_STAT, 32'h1 << bmcr_pkg::STAT_DONE);
  endtask

  task automatic resetRegs();
    check(32'(busAreaStatus), 32'h7);
    check(32'({cycleStartStrobe_b, addrStrobe_b, dataStrobe_b}), 32'h7);
    check(32'(dataOe), 32'h0);
    apb(1'b0, bmcr_pkg::OFF_CFG, 32'h0);
    check(rdv, 32'(bmcr_pkg::CFG_RESET));
    check(32'(errv), 32'h0);
    apb(1'b0, bmcr_pkg::OFF_STAT, 32'h0);
    check(rdv, 32'h0);
    apb(1'b1, 8'h20, 32'hffff_ffff);
    check(32'(errv), 32'h1);
  endtask

  task automatic runCycle(input logic m, input logic sy, input logic [1:0] w,
    input logic wrt, input logic [3:0] idx);
    logic [15:0] wd;
    wd = 16'hc000 | 16'({idx, w, m, sy});
    byteOrderModePin <= m;
    startCycle(32'(sy) | (32'(w) << bmcr_pkg::CFG_WAIT_LO), wrt, idx, wd);
    waitDone();
    check(32'(capPins[25:23]), 32'h5);
    check(32'(capPins[26]), 32'(m ^ wrt));
    if (wrt)
    begin
      check(32'(bmcr_mem_model_i.mem[idx]), 32'(wd));
      // acknowledge comes after the first T2, so each async write waits
      if (!sy)
        check(32'(dsSeen), 32'h1);
      else if (m && w != 2'h0)
        check(32'(dsSeen), 32'h1);
    end
    else
    begin
      apb(1'b0, bmcr_pkg::OFF_RDATA, 32'h0);
      check(rdv & 32'hffff, 32'h5a00 + 32'(idx));
      if (m || !sy)
        check(32'(dsSeen), 32'h1);
    end
  endtask

  task automatic retryRepeat();
    int n;
    n = csCount;
    byteOrderModePin <= 1'b0;
    doRetry <= 1'b1;
    startCycle(32'h1 << bmcr_pkg::CFG_WAIT_LO, 1'b0, 4'h3, 16'h0);
    wait (busRequestOut === 1'b1);
    wait (busRequestOut === 1'b0);
    wait (busRequestOut === 1'b1);
    @(posedge clk);
    doRetry <= 1'b0;
    waitDone();
    apb(1'b0, bmcr_pkg::OFF_STAT, 32'h0);
    check(32'(rdv[bmcr_pkg::STAT_RETRY]), 32'h1);
    apb(1'b1, bmcr_pkg::OFF_STAT, 32'h1 << bmcr_pkg::STAT_RETRY);
    check(32'(csCount - n), 32'h2);
    apb(1'b0, bmcr_pkg::OFF_RDATA, 32'h0);
    check(rdv & 32'hffff, 32'h5a03);
  endtask

  task automatic retryLatched();
    int n;
    logic [31:0] cfg;
    n = csCount;
    cfg = (32'h1 << bmcr_pkg::CFG_LATCH_RETRY) |
      (32'h1 << bmcr_pkg::CFG_RETRY_ASYNC) | (32'h1 << bmcr_pkg::CFG_HOLD_EDGE);
    doRetry <= 1'b1;
    startCycle(cfg, 1'b1, 4'h9, 16'h1234);
    do
      apb(1'b0, bmcr_pkg::OFF_STAT, 32'h0);
    while (rdv[bmcr_pkg::STAT_RETRY] !== 1'b1);
    repeat (20) @(posedge clk);
    check(32'(busRequestOut), 32'h0);
    apb(1'b0, bmcr_pkg::OFF_STAT, 32'h0);
    check(32'(rdv[bmcr_pkg::STAT_DONE]), 32'h0);
    doRetry <= 1'b0;
    apb(1'b1, bmcr_pkg::OFF_STAT, 32'h1 << bmcr_pkg::STAT_RETRY);
    waitDone();
    check(32'(csCount - n), 32'h2);
    check(32'(bmcr_mem_model_i.mem[9]), 32'h1234);
  endtask

  task automatic zeroWaitWrite();
    early <= 1'b1;
    byteOrderModePin <= 1'b0;
    startCycle(32'h0, 1'b1, 4'h6, 16'h0bad);
    waitDone();
    early <= 1'b0;
    check(32'(dsSeen), 32'h0);
    check(32'(bmcr_mem_model_i.mem[6]), 32'h0bad);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    resetRegs();
    for (int i = 0; i < 16; i++)
    begin
      slow <= i[0];
      useTerm <= i[3] & !i[2] & i[1];
      runCycle(i[3], i[2], i[1:0], 1'b0, {1'b0, i[2:0]});
      runCycle(i[3], i[2], i[1:0], 1'b1, {1'b1, i[2:0]});
    end
    retryRepeat();
    retryLatched();
    zeroWaitWrite();
    give_verdict();
  end
endmodule
